/* File: include/dpnc_regs.svh */
// Register map, field positions and reset values of the correction core
`ifndef DPNC_REGS_SVH
`define DPNC_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DPNC_CTRL_OFS 12'h000
`define DPNC_SEL_OFS 12'h004
`define DPNC_CMD_OFS 12'h008
`define DPNC_STAT_OFS 12'h00C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DPNC_CTRL_DARK_EN 0
`define DPNC_CTRL_GAIN_EN 1
`define DPNC_SEL_DARK_LSB 0
`define DPNC_SEL_GAIN_LSB 8
`define DPNC_CMD_DGEN 0
`define DPNC_CMD_DSAVE 1
`define DPNC_CMD_DLOAD 2
`define DPNC_CMD_GGEN 3
`define DPNC_CMD_GSAVE 4
`define DPNC_CMD_GLOAD 5
`define DPNC_STAT_BUSY 0
`define DPNC_STAT_REFUSED 1
`define DPNC_STAT_WAIT 2
`define DPNC_STAT_DARK_NEW 3
`define DPNC_STAT_GAIN_NEW 4

// ----------------------------------------
// Reset values and table constants
// ----------------------------------------
`define DPNC_CTRL_RST 2'h0
`define DPNC_SEL_RST 2'h0
`define DPNC_DEPTH 16
`define DPNC_LAST_IDX 4'hF
`define DPNC_DEFAULT_SLOT 2'h0
`define DPNC_DARK_RST 8'h00
`define DPNC_GAIN_ONE 8'h40
`define DPNC_GAIN_MAX 8'hFF
`define DPNC_GAIN_TARGET 8'hAF

`endif

/* File: include/dpnc_pkg.sv */
// Types shared by the correction core and its table store
package dpnc_pkg;
  typedef logic [7:0] dpnc_pix_type;
  typedef logic [3:0] dpnc_idx_type;
  typedef logic [1:0] dpnc_slot_type;
  typedef enum logic [2:0] {
    DPNC_IDLE = 3'b000,
    DPNC_GEN_WAIT = 3'b001,
    DPNC_GEN_RUN = 3'b010,
    DPNC_SAVE = 3'b011,
    DPNC_LOAD = 3'b100
  } dpnc_state_type;
  typedef enum logic {
    DPNC_TBL_DARK = 1'b0,
    DPNC_TBL_GAIN = 1'b1
  } dpnc_tbl_type;
endpackage

/* File: include/dpnc_nv_if.sv */
// Link between the command sequencer and the slot store
`timescale 1ns/1ps
`default_nettype none
interface dpnc_nv_if;
  logic wr_en;
  dpnc_pkg::dpnc_tbl_type tbl;
  dpnc_pkg::dpnc_slot_type slot;
  dpnc_pkg::dpnc_idx_type idx;
  dpnc_pkg::dpnc_pix_type wdata;
  dpnc_pkg::dpnc_pix_type rdata;
  modport ctrl (
    output wr_en, tbl, slot, idx, wdata,
    input rdata
  );
  modport store (
    input wr_en, tbl, slot, idx, wdata,
    output rdata
  );
endinterface
`default_nettype wire

/* File: core/dpnc_nv_store.sv */
// Slot store: fixed default slot plus user slots kept over reset
`timescale 1ns/1ps
`default_nettype none
`include "dpnc_regs.svh"
module dpnc_nv_store (
  // Clock
  input wire logic ref_clk_in,
  // Sequencer side
  dpnc_nv_if.store nv
);
  import dpnc_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  dpnc_pix_type mem_r [0:127];
  logic [6:0] addr;
  logic [1:0] user_slot;

  // User slots 1..3 map onto rows 0..2
  assign user_slot = nv.slot - 2'h1;
  assign addr = {nv.tbl, user_slot, nv.idx};

  // One entry per flop group, never reset
  for (genvar g = 0; g < 128; g++) begin : g_mem
    always_ff @(posedge ref_clk_in) begin
      if (nv.wr_en && nv.slot != `DPNC_DEFAULT_SLOT &&
          addr == 7'(g)) begin
        mem_r[g] <= nv.wdata;
      end
    end
  end

  // Registered read, default slot is constant
  always_ff @(posedge ref_clk_in) begin
    if (nv.slot == `DPNC_DEFAULT_SLOT) begin
      nv.rdata <= (nv.tbl == DPNC_TBL_GAIN) ? `DPNC_GAIN_ONE
                                             : `DPNC_DARK_RST;
    end else begin
      nv.rdata <= mem_r[addr];
    end
  end
endmodule
`default_nettype wire

/* File: core/dpnc_top.sv */
// Dark offset and gain correction core with APB command registers
// Notes on behaviour
// - dark generate captures offsets from one frame
// - gain generate derives gains from one frame
// - generated table active at once, volatile
// - active tables reset; saved slots survive
// - dark save writes active table to slot
// - gain save writes active table to slot
// - save overwrites slot contents entirely
// - dark load copies slot into active table
// - gain load copies slot into active table
// - default slot loadable, save refused
// - user slots 1..3 save and load
`timescale 1ns/1ps
`default_nettype none
`include "dpnc_regs.svh"
module dpnc_top (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Raw pixel stream
  input wire logic pix_valid_in,
  input wire logic pix_sof_in,
  input wire logic pix_eof_in,
  input wire dpnc_pkg::dpnc_idx_type pix_idx_in,
  input wire dpnc_pkg::dpnc_pix_type pix_data_in,
  // Corrected pixel stream
  output logic pix_valid_out,
  output logic pix_sof_out,
  output logic pix_eof_out,
  output dpnc_pkg::dpnc_pix_type pix_data_out
);
  import dpnc_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic wr_acc;
  logic rd_setup;
  logic hit;
  logic [1:0] ctrl_r;
  dpnc_slot_type dsel_r;
  dpnc_slot_type gsel_r;
  logic [5:0] cmd;
  logic busy;
  logic go_gen;
  logic go_save;
  logic go_load;
  logic bad;
  dpnc_tbl_type go_tbl;
  dpnc_state_type state_r;
  dpnc_tbl_type tbl_r;
  dpnc_slot_type slot_r;
  dpnc_idx_type idx_r;
  logic ld_vld_r;
  dpnc_tbl_type ld_tbl_r;
  dpnc_idx_type ld_idx_r;
  logic gen_we;
  logic gen_done;
  logic refused_r;
  logic dark_new_r;
  logic gain_new_r;
  dpnc_pix_type dark_r [0:`DPNC_DEPTH-1];
  dpnc_pix_type gain_r [0:`DPNC_DEPTH-1];
  dpnc_pix_type cur_dark;
  dpnc_pix_type raw_diff;
  logic [13:0] gain_num;
  logic [13:0] gain_quot;
  dpnc_pix_type gain_gen;
  dpnc_pix_type gen_val;
  logic s1_vld_r;
  logic s1_sof_r;
  logic s1_eof_r;
  dpnc_pix_type s1_diff_r;
  dpnc_pix_type s1_gain_r;
  logic [15:0] prod;
  logic [31:0] prdata_r;
  dpnc_nv_if nv_bus ();

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Access and setup phase qualifiers
  assign wr_acc = psel_in & penable_in & pwrite_in;
  assign rd_setup = psel_in & ~penable_in & ~pwrite_in;

  // Address decode
  always_comb begin
    case (paddr_in)
      `DPNC_CTRL_OFS: hit = 1'b1;
      `DPNC_SEL_OFS: hit = 1'b1;
      `DPNC_CMD_OFS: hit = 1'b1;
      `DPNC_STAT_OFS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Zero wait states, error on unmapped
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit;
  assign prdata_out = prdata_r;

  // Correction enables
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= `DPNC_CTRL_RST;
    end else if (wr_acc && paddr_in == `DPNC_CTRL_OFS) begin
      ctrl_r <= pwdata_in[1:0];
    end
  end

  // Slot selectors
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dsel_r <= `DPNC_SEL_RST;
      gsel_r <= `DPNC_SEL_RST;
    end else if (wr_acc && paddr_in == `DPNC_SEL_OFS) begin
      dsel_r <= pwdata_in[`DPNC_SEL_DARK_LSB +: 2];
      gsel_r <= pwdata_in[`DPNC_SEL_GAIN_LSB +: 2];
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_r <= 32'h0000_0000;
      case (paddr_in)
        `DPNC_CTRL_OFS: prdata_r[1:0] <= ctrl_r;
        `DPNC_SEL_OFS: begin
          prdata_r[`DPNC_SEL_DARK_LSB +: 2] <= dsel_r;
          prdata_r[`DPNC_SEL_GAIN_LSB +: 2] <= gsel_r;
        end
        `DPNC_STAT_OFS: begin
          prdata_r[`DPNC_STAT_BUSY] <= busy;
          prdata_r[`DPNC_STAT_REFUSED] <= refused_r;
          prdata_r[`DPNC_STAT_WAIT] <= (state_r != DPNC_IDLE) &&
            (state_r != DPNC_SAVE) && (state_r != DPNC_LOAD);
          prdata_r[`DPNC_STAT_DARK_NEW] <= dark_new_r;
          prdata_r[`DPNC_STAT_GAIN_NEW] <= gain_new_r;
        end
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Command bits act only in the write access cycle
  assign cmd = (wr_acc && paddr_in == `DPNC_CMD_OFS) ?
               pwdata_in[5:0] : 6'h00;
  assign busy = (state_r != DPNC_IDLE) | ld_vld_r;

  // Lowest set bit wins, busy or bad target refuses
  always_comb begin
    go_gen = 1'b0;
    go_save = 1'b0;
    go_load = 1'b0;
    go_tbl = DPNC_TBL_DARK;
    bad = 1'b0;
    if (|cmd) begin
      if (busy) begin
        bad = 1'b1;
      end else if (cmd[`DPNC_CMD_DGEN]) begin
        go_gen = 1'b1;
      end else if (cmd[`DPNC_CMD_DSAVE]) begin
        bad = (dsel_r == `DPNC_DEFAULT_SLOT);
        go_save = ~bad;
      end else if (cmd[`DPNC_CMD_DLOAD]) begin
        go_load = 1'b1;
      end else if (cmd[`DPNC_CMD_GGEN]) begin
        go_gen = 1'b1;
        go_tbl = DPNC_TBL_GAIN;
      end else if (cmd[`DPNC_CMD_GSAVE]) begin
        go_tbl = DPNC_TBL_GAIN;
        bad = (gsel_r == `DPNC_DEFAULT_SLOT);
        go_save = ~bad;
      end else begin
        go_tbl = DPNC_TBL_GAIN;
        go_load = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  // One command at a time
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= DPNC_IDLE;
      tbl_r <= DPNC_TBL_DARK;
      slot_r <= `DPNC_DEFAULT_SLOT;
      idx_r <= 4'h0;
    end else begin
      case (state_r)
        DPNC_IDLE: begin
          idx_r <= 4'h0;
          tbl_r <= go_tbl;
          slot_r <= (go_tbl == DPNC_TBL_GAIN) ? gsel_r : dsel_r;
          if (go_gen) begin
            state_r <= DPNC_GEN_WAIT;
          end else if (go_save) begin
            state_r <= DPNC_SAVE;
          end else if (go_load) begin
            state_r <= DPNC_LOAD;
          end
        end
        DPNC_GEN_WAIT: begin
          if (pix_valid_in && pix_sof_in) begin
            state_r <= DPNC_GEN_RUN;
          end
        end
        DPNC_GEN_RUN: begin
          if (gen_done) begin
            state_r <= DPNC_IDLE;
          end
        end
        DPNC_SAVE, DPNC_LOAD: begin
          idx_r <= idx_r + 4'h1;
          if (idx_r == `DPNC_LAST_IDX) begin
            state_r <= DPNC_IDLE;
          end
        end
        default: state_r <= DPNC_IDLE;
      endcase
    end
  end

  // Load data returns one cycle after its address
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ld_vld_r <= 1'b0;
      ld_tbl_r <= DPNC_TBL_DARK;
      ld_idx_r <= 4'h0;
    end else begin
      ld_vld_r <= (state_r == DPNC_LOAD);
      ld_tbl_r <= tbl_r;
      ld_idx_r <= idx_r;
    end
  end

  // Slot store walks the active table on save
  assign nv_bus.wr_en = (state_r == DPNC_SAVE);
  assign nv_bus.tbl = tbl_r;
  assign nv_bus.slot = slot_r;
  assign nv_bus.idx = idx_r;
  assign nv_bus.wdata = (tbl_r == DPNC_TBL_GAIN) ? gain_r[idx_r]
                                                  : dark_r[idx_r];

  dpnc_nv_store u_store (
    .ref_clk_in(ref_clk_in),
    .nv(nv_bus.store)
  );

  // ----------------------------------------
  // Table generation
  // ----------------------------------------
  // Capture window is exactly one frame
  assign gen_we = pix_valid_in &&
                  ((state_r == DPNC_GEN_WAIT && pix_sof_in) ||
                   state_r == DPNC_GEN_RUN);
  assign gen_done = (state_r == DPNC_GEN_RUN) &&
                    pix_valid_in && pix_eof_in;

  // Raw level above the present dark offset
  assign cur_dark = dark_r[pix_idx_in];
  assign raw_diff = (pix_data_in > cur_dark) ?
                    pix_data_in - cur_dark : 8'h00;

  // Gain brings the pixel to the target level
  assign gain_num = {`DPNC_GAIN_TARGET, 6'h00};
  assign gain_quot = gain_num / {6'h00, raw_diff};

  always_comb begin
    if (raw_diff == 8'h00 || |gain_quot[13:8]) begin
      gain_gen = `DPNC_GAIN_MAX;
    end else begin
      gain_gen = gain_quot[7:0];
    end
  end

  // Dark table takes the raw dark level
  assign gen_val = (tbl_r == DPNC_TBL_GAIN) ? gain_gen
                                             : pix_data_in;

  // ----------------------------------------
  // Active volatile tables
  // ----------------------------------------
  // Each entry from generate or load, neutral at reset
  for (genvar g = 0; g < `DPNC_DEPTH; g++) begin : g_ent
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        dark_r[g] <= `DPNC_DARK_RST;
        gain_r[g] <= `DPNC_GAIN_ONE;
      end else if (gen_we && pix_idx_in == 4'(g)) begin
        if (tbl_r == DPNC_TBL_GAIN) begin
          gain_r[g] <= gen_val;
        end else begin
          dark_r[g] <= gen_val;
        end
      end else if (ld_vld_r && ld_idx_r == 4'(g)) begin
        if (ld_tbl_r == DPNC_TBL_GAIN) begin
          gain_r[g] <= nv_bus.rdata;
        end else begin
          dark_r[g] <= nv_bus.rdata;
        end
      end
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Refusal is sticky, write one clears, set wins
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      refused_r <= 1'b0;
    end else if (bad) begin
      refused_r <= 1'b1;
    end else if (wr_acc && paddr_in == `DPNC_STAT_OFS &&
                 pwdata_in[`DPNC_STAT_REFUSED]) begin
      refused_r <= 1'b0;
    end
  end

  // Unsaved generated table markers
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dark_new_r <= 1'b0;
      gain_new_r <= 1'b0;
    end else begin
      if (gen_done && tbl_r == DPNC_TBL_DARK) begin
        dark_new_r <= 1'b1;
      end else if ((go_save || go_load) && go_tbl == DPNC_TBL_DARK) begin
        dark_new_r <= 1'b0;
      end
      if (gen_done && tbl_r == DPNC_TBL_GAIN) begin
        gain_new_r <= 1'b1;
      end else if ((go_save || go_load) && go_tbl == DPNC_TBL_GAIN) begin
        gain_new_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Correction pipeline
  // ----------------------------------------
  // Stage one: offset removal and gain lookup
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_vld_r <= 1'b0;
      s1_sof_r <= 1'b0;
      s1_eof_r <= 1'b0;
      s1_diff_r <= 8'h00;
      s1_gain_r <= `DPNC_GAIN_ONE;
    end else begin
      s1_vld_r <= pix_valid_in;
      s1_sof_r <= pix_valid_in & pix_sof_in;
      s1_eof_r <= pix_valid_in & pix_eof_in;
      s1_diff_r <= ctrl_r[`DPNC_CTRL_DARK_EN] ?
                   raw_diff : pix_data_in;
      s1_gain_r <= ctrl_r[`DPNC_CTRL_GAIN_EN] ?
                   gain_r[pix_idx_in] : `DPNC_GAIN_ONE;
    end
  end

  // Gain has six fraction bits
  assign prod = s1_diff_r * s1_gain_r;

  // Stage two: scale and clamp to pixel range
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pix_valid_out <= 1'b0;
      pix_sof_out <= 1'b0;
      pix_eof_out <= 1'b0;
      pix_data_out <= 8'h00;
    end else begin
      pix_valid_out <= s1_vld_r;
      pix_sof_out <= s1_sof_r;
      pix_eof_out <= s1_eof_r;
      if (|prod[15:14]) begin
        pix_data_out <= 8'hFF;
      end else begin
        pix_data_out <= prod[13:6];
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/dpnc_host_model.sv */
// Host model: APB command master and free-running pixel source
`timescale 1ns/1ps
`default_nettype none
module dpnc_host_model (
  // Clock
  input wire logic clk_in,
  // APB master side
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  // Pixel source side
  output logic pix_valid_out,
  output logic pix_sof_out,
  output logic pix_eof_out,
  output dpnc_pkg::dpnc_idx_type pix_idx_out,
  output dpnc_pkg::dpnc_pix_type pix_data_out
);
  import dpnc_pkg::*;

  // Idle levels at time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
    pix_valid_out = 1'b0;
    pix_sof_out = 1'b0;
    pix_eof_out = 1'b0;
    pix_idx_out = 4'h0;
    pix_data_out = 8'h00;
  end

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] addr,
      input logic [31:0] wdata, output logic [31:0] rdata,
      output logic err);
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= addr;
    pwdata_out <= wdata;
    @(posedge clk_in);
    penable_out <= 1'b1;
    @(posedge clk_in);
    while (pready_in !== 1'b1) begin
      @(posedge clk_in);
    end
    rdata = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~addr;
    pwdata_out <= ~wdata;
  endtask

  // One pixel beat; back-to-back calls give a gapless stream
  task automatic pix(input dpnc_idx_type idx, input dpnc_pix_type d,
      input logic sof, input logic eof);
    @(posedge clk_in);
    pix_valid_out <= 1'b1;
    pix_sof_out <= sof;
    pix_eof_out <= eof;
    pix_idx_out <= idx;
    pix_data_out <= d;
  endtask

  // Stream stops; stale data inverted so it is never mistaken
  task automatic pix_idle();
    @(posedge clk_in);
    pix_valid_out <= 1'b0;
    pix_sof_out <= 1'b0;
    pix_eof_out <= 1'b0;
    pix_data_out <= ~pix_data_out;
  endtask

  // Whole free-running frame, raw levels with no flat-field step
  task automatic frame(input dpnc_pix_type base);
    for (int i = 0; i < 16; i++) begin
      pix(4'(i), base + 8'(i), i == 0, i == 15);
    end
    pix_idle();
  endtask
endmodule
`default_nettype wire

/* File: verif/dpnc_top_sva.sv */
// Assertion checker for the correction core ports
`timescale 1ns/1ps
`default_nettype none
`include "dpnc_regs.svh"
module dpnc_top_sva (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Pixels
  input wire logic pix_valid_in,
  input wire logic pix_sof_in,
  input wire logic pix_eof_in,
  input wire dpnc_pkg::dpnc_idx_type pix_idx_in,
  input wire dpnc_pkg::dpnc_pix_type pix_data_in,
  input wire logic pix_valid_out,
  input wire logic pix_sof_out,
  input wire logic pix_eof_out,
  input wire dpnc_pkg::dpnc_pix_type pix_data_out
);
  import dpnc_pkg::*;
  logic apb_wr;
  logic [31:0] ctrl_r;
  logic [31:0] sel_r;

  // Completed write
  assign apb_wr = psel_in && penable_in && pwrite_in && pready_out;

  // Shadow of the enable register
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= 32'h0000_0000;
    end else if (apb_wr && paddr_in == `DPNC_CTRL_OFS) begin
      ctrl_r <= pwdata_in & 32'h0000_0003;
    end
  end

  // Shadow of the slot selector register
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_r <= 32'h0000_0000;
    end else if (apb_wr && paddr_in == `DPNC_SEL_OFS) begin
      sel_r <= pwdata_in & 32'h0000_0303;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Read setup cycle at one address
  sequence s_rd_setup(logic [11:0] a);
    psel_in && !penable_in && !pwrite_in && paddr_in == a;
  endsequence
  // Pixel entering with both corrections off for its two stages
  sequence s_raw_path;
    pix_valid_in && ctrl_r == 32'h0000_0000 ##1 ctrl_r == 32'h0000_0000;
  endsequence

  a_valid_delay: assert property (pix_valid_in |-> ##2 pix_valid_out)
    else $error("pixel valid not delayed by two cycles");
  a_valid_gap: assert property (!pix_valid_in |-> ##2 !pix_valid_out)
    else $error("pixel valid out without input");
  a_sof_delay: assert property (
    pix_valid_in && pix_sof_in |-> ##2 pix_sof_out)
    else $error("frame start marker lost");
  a_eof_delay: assert property (
    pix_valid_in && pix_eof_in |-> ##2 pix_eof_out)
    else $error("frame end marker lost");
  a_raw_pass: assert property (
    s_raw_path |=> pix_data_out == $past(pix_data_in, 2))
    else $error("uncorrected pixel altered");
  a_ctrl_readback: assert property (
    s_rd_setup(`DPNC_CTRL_OFS) |=> prdata_out == $past(ctrl_r))
    else $error("enable register readback wrong");
  a_sel_readback: assert property (
    s_rd_setup(`DPNC_SEL_OFS) |=> prdata_out == $past(sel_r))
    else $error("selector readback wrong");
  a_cmd_reads_zero: assert property (
    s_rd_setup(`DPNC_CMD_OFS) |=> prdata_out == 32'h0000_0000)
    else $error("command register not reading zero");
  a_unmapped_error: assert property (
    psel_in && penable_in && !(paddr_in inside {`DPNC_CTRL_OFS,
    `DPNC_SEL_OFS, `DPNC_CMD_OFS, `DPNC_STAT_OFS}) |-> pslverr_out)
    else $error("unmapped access without error");
endmodule

bind dpnc_top dpnc_top_sva u_sva (.ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .pix_valid_in(pix_valid_in),
  .pix_sof_in(pix_sof_in), .pix_eof_in(pix_eof_in),
  .pix_idx_in(pix_idx_in), .pix_data_in(pix_data_in),
  .pix_valid_out(pix_valid_out), .pix_sof_out(pix_sof_out),
  .pix_eof_out(pix_eof_out), .pix_data_out(pix_data_out));
`default_nettype wire

/* File: verif/dpnc_top_bench.sv */
// Self-checking bench for the correction core
`timescale 1ns/1ps
`default_nettype none
`include "dpnc_regs.svh"
module dpnc_top_bench;
  import dpnc_pkg::*;
  logic clk, rst_n, psel, pen, pwr, rdy, err, vi, si, ei, vo, so, eo;
  logic [11:0] addr;
  logic [31:0] wd, rd;
  dpnc_idx_type idx;
  dpnc_pix_type di, dout;
  int err_count = 0;
  int checks_done = 0;

  dpnc_top u_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wd),
    .prdata_out(rd), .pready_out(rdy), .pslverr_out(err),
    .pix_valid_in(vi), .pix_sof_in(si), .pix_eof_in(ei), .pix_idx_in(idx),
    .pix_data_in(di), .pix_valid_out(vo), .pix_sof_out(so),
    .pix_eof_out(eo), .pix_data_out(dout));
  dpnc_host_model u_host (.clk_in(clk), .psel_out(psel), .penable_out(pen),
    .pwrite_out(pwr), .paddr_out(addr), .pwdata_out(wd), .prdata_in(rd),
    .pready_in(rdy), .pslverr_in(err), .pix_valid_out(vi),
    .pix_sof_out(si), .pix_eof_out(ei), .pix_idx_out(idx),
    .pix_data_out(di));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Comparison with report
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register access helpers
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    u_host.apb(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a,
      input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    u_host.apb(1'b0, a, 32'h0000_0000, q, e);
    chk(what, exp, q & m);
  endtask
  task automatic cmd(input int b);
    wr(`DPNC_CMD_OFS, 32'h0000_0001 << b);
  endtask

  // Poll busy low, bounded
  task automatic wait_idle();
    logic [31:0] q;
    logic e;
    q = 32'h0000_0001;
    for (int n = 0; n < 40 && q[0] !== 1'b0; n++) begin
      u_host.apb(1'b0, `DPNC_STAT_OFS, 32'h0000_0000, q, e);
    end
    chk("busy", 32'h0000_0000, {31'h0000_0000, q[0]});
  endtask

  // Single pixel through the pipeline
  task automatic pix_chk(input dpnc_idx_type i, input dpnc_pix_type d,
      input dpnc_pix_type exp);
    u_host.pix(i, d, 1'b0, 1'b0);
    u_host.pix_idle();
    #1;
    for (int n = 0; n < 4 && vo !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("pixel valid", 32'h0000_0001, {31'h0000_0000, vo});
    chk("pixel", {24'h00_0000, exp}, {24'h00_0000, dout});
  endtask

  // Reset values, unmapped address, raw path
  task automatic t_reset_vals();
    logic [31:0] q;
    logic e;
    rd_chk("ctrl", `DPNC_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk("stat", `DPNC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk("cmd", `DPNC_CMD_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    u_host.apb(1'b0, 12'h010, 32'h0000_0000, q, e);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, e});
    pix_chk(4'h3, 8'h5A, 8'h5A);
  endtask

  // Dark generate, refusals, overwrite of a user slot
  task automatic t_dark();
    wr(`DPNC_CTRL_OFS, 32'h0000_0001);
    wr(`DPNC_SEL_OFS, 32'h0000_0001);
    cmd(`DPNC_CMD_DGEN);
    rd_chk("stat gen", `DPNC_STAT_OFS, 32'h0000_0007, 32'h0000_0005);
    u_host.frame(8'h14);
    wait_idle();
    rd_chk("stat new", `DPNC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0008);
    cmd(`DPNC_CMD_DSAVE);
    cmd(`DPNC_CMD_DLOAD);
    rd_chk("stat busy", `DPNC_STAT_OFS, 32'h0000_0003, 32'h0000_0003);
    wait_idle();
    rd_chk("stat saved", `DPNC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0002);
    wr(`DPNC_STAT_OFS, 32'h0000_0002);
    cmd(`DPNC_CMD_DGEN);
    u_host.frame(8'h0A);
    wait_idle();
    pix_chk(4'h3, 8'h32, 8'h25);
    pix_chk(4'h3, 8'h05, 8'h00);
    wr(`DPNC_SEL_OFS, 32'h0000_0000);
    cmd(`DPNC_CMD_DSAVE);
    rd_chk("stat slot0", `DPNC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_000A);
    wr(`DPNC_STAT_OFS, 32'h0000_0002);
    wr(`DPNC_SEL_OFS, 32'h0000_0001);
    cmd(`DPNC_CMD_DSAVE);
    wait_idle();
    rd_chk("stat clear", `DPNC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask

  // Mid-run reset drops active table, user slot survives
  task automatic t_reset_keep();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(`DPNC_CTRL_OFS, 32'h0000_0001);
    pix_chk(4'h3, 8'h32, 8'h32);
    wr(`DPNC_SEL_OFS, 32'h0000_0001);
    cmd(`DPNC_CMD_DLOAD);
    wait_idle();
    pix_chk(4'h3, 8'h32, 8'h25);
  endtask

  // Gain generate, clamp, save, default and user loads
  task automatic t_gain();
    wr(`DPNC_CTRL_OFS, 32'h0000_0003);
    rd_chk("ctrl", `DPNC_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0003);
    cmd(`DPNC_CMD_GGEN);
    u_host.frame(8'hA0);
    wait_idle();
    rd_chk("stat gain", `DPNC_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0010);
    pix_chk(4'h2, 8'h3E, 8'h39);
    pix_chk(4'h2, 8'hFF, 8'hFF);
    wr(`DPNC_SEL_OFS, 32'h0000_0201);
    rd_chk("sel", `DPNC_SEL_OFS, 32'hFFFF_FFFF, 32'h0000_0201);
    cmd(`DPNC_CMD_GSAVE);
    wait_idle();
    wr(`DPNC_SEL_OFS, 32'h0000_0001);
    cmd(`DPNC_CMD_GLOAD);
    wait_idle();
    pix_chk(4'h2, 8'h3E, 8'h32);
    wr(`DPNC_SEL_OFS, 32'h0000_0201);
    cmd(`DPNC_CMD_GLOAD);
    wait_idle();
    pix_chk(4'h2, 8'h3E, 8'h39);
  endtask

  // Watchdog, far beyond the expected run length
  initial begin
    #50000;
    err_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_vals();
    t_dark();
    t_reset_keep();
    t_gain();
    tally_and_finish();
  end
endmodule
`default_nettype wire
